/* src/ifr_pkg.sv */
// Package: register map, field positions and carriers for the flag block
package ifr_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;

   // Register indices on the plain register port
   localparam logic [3:0] OFF_FLAG_FIVE   = 4'h0;
   localparam logic [3:0] OFF_FLAG_SIX    = 4'h1;
   localparam logic [3:0] OFF_EN_TWO      = 4'h2;
   localparam logic [3:0] OFF_EN_THREE    = 4'h3;
   localparam logic [3:0] OFF_EN_FIVE     = 4'h4;
   localparam logic [3:0] OFF_EN_SIX      = 4'h5;
   localparam logic [3:0] OFF_WAKE_CTRL   = 4'h6;
   localparam logic [3:0] OFF_EVT_STATUS  = 4'h7;
   localparam logic [3:0] OFF_EVT_MASK    = 4'h8;

   // Field positions
   localparam int unsigned BIT_LPW_FLAG   = 0;
   localparam int unsigned BIT_LC1_FLAG   = 0;
   localparam int unsigned BIT_LC2_FLAG   = 1;
   localparam int unsigned BIT_CC5_EN     = 9;
   localparam int unsigned BIT_CAL_EN     = 14;
   localparam int unsigned BIT_S2COL_EN   = 2;
   localparam int unsigned BIT_S2EVT_EN   = 1;
   localparam int unsigned BIT_LPW_EN     = 0;
   localparam int unsigned BIT_LC1_EN     = 0;
   localparam int unsigned BIT_LC2_EN     = 1;
   localparam int unsigned BIT_WAKE_ON    = 15;
   localparam int unsigned BIT_WAKE_IDLE  = 13;
   localparam int unsigned BIT_WAKE_SINK  = 8;

   // Implemented-bit masks
   localparam logic [15:0] MSK_FLAG_FIVE  = 16'h0001;
   localparam logic [15:0] MSK_FLAG_SIX   = 16'h0003;
   localparam logic [15:0] MSK_EN_TWO     = 16'h0200;
   localparam logic [15:0] MSK_EN_THREE   = 16'h4006;
   localparam logic [15:0] MSK_EN_FIVE    = 16'h0001;
   localparam logic [15:0] MSK_EN_SIX     = 16'h0003;
   localparam logic [15:0] MSK_WAKE_CTRL  = 16'hA100;
   localparam logic [15:0] MSK_EVT        = 16'h0007;
   localparam logic [15:0] RST_VALUE      = 16'h0000;

   // Sources feeding the flags
   typedef struct packed {
      logic lc2;
      logic lc1;
      logic lpw;
   } ifr_src_t;

   // Requests toward the processor
   typedef struct packed {
      logic cc5_timer;
      logic calendar;
      logic s2_collision;
      logic s2_event;
      logic lc2;
      logic lc1;
      logic lpw;
   } ifr_req_t;
endpackage : ifr_pkg

/* src/ifr_flag_bit.sv */
// One hardware-settable, software-writable flag bit
`timescale 1ns/10ps
module ifr_flag_bit (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_hw_set,
   input  wire logic i_sw_wr,
   input  wire logic i_sw_val,
   output logic      o_flag
);
   logic flag_q;
   logic flag_d;

   // Hardware set beats a same-cycle software clear
   assign flag_d = i_hw_set ? 1'b1 : (i_sw_wr ? i_sw_val : flag_q);

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign o_flag = flag_q;
endmodule : ifr_flag_bit

/* src/ifr_regs.sv */
// Interrupt flag, enable and wake-unit control registers
//
// Function
// RULE1 - Wake flag sits in bit 0, flag five
// RULE2 - Cell flags at bits 0 and 1, six
// RULE3 - Flags set by hardware, software read/write
// RULE4 - Timer five enable at bit 9
// RULE5 - Calendar enable at bit 14, register three
// RULE6 - Serial collision bit 2, event bit 1
// RULE7 - Wake enable at bit 0, register five
// RULE8 - Cell enables bits 0 and 1, six
// RULE9 - Enable one permits request, resets zero
// RULE10 - Unimplemented bits read zero, ignore writes
// RULE11 - Control bit 15 turns wake unit on
// RULE12 - Control bit 13 stops unit in idle
// RULE13 - Control bit 8 turns current sink on
// RULE14 - Request only when flag and enable set
// RULE15 - Software clears flag; hardware set wins
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module ifr_regs
   import ifr_pkg::*;
(
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst,
   input  wire logic [ifr_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [ifr_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   input  wire ifr_pkg::ifr_src_t     i_src,
   input  wire logic                  i_cc5_timer_req,
   input  wire logic                  i_calendar_req,
   input  wire logic                  i_s2_collision_req,
   input  wire logic                  i_s2_event_req,
   input  wire logic                  i_idle,
   output logic [ifr_pkg::DATA_W-1:0] o_rdata,
   output ifr_pkg::ifr_req_t          o_req,
   output logic                       o_wake_active,
   output logic                       o_wake_sink_on,
   output logic                       o_irq
);
   import ifr_pkg::*;

   // All checks share the core clock and reset
   default clocking cb_core @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   // Register storage
   logic [15:0] en_two_q;
   logic [15:0] en_three_q;
   logic [15:0] en_five_q;
   logic [15:0] en_six_q;
   logic [15:0] wake_ctrl_q;
   logic [15:0] evt_stat_q;
   logic [15:0] evt_mask_q;
   logic [15:0] rdata_q;
   ifr_req_t    req_q;
   logic        wake_active_q;
   logic        sink_q;
   logic        irq_q;
   logic [2:0]  src_prev_q;

   // Decode
   wire wr_flag5 = i_wr && (i_addr == OFF_FLAG_FIVE);
   wire wr_flag6 = i_wr && (i_addr == OFF_FLAG_SIX);
   wire wr_en2   = i_wr && (i_addr == OFF_EN_TWO);
   wire wr_en3   = i_wr && (i_addr == OFF_EN_THREE);
   wire wr_en5   = i_wr && (i_addr == OFF_EN_FIVE);
   wire wr_en6   = i_wr && (i_addr == OFF_EN_SIX);
   wire wr_wake  = i_wr && (i_addr == OFF_WAKE_CTRL);
   wire wr_stat  = i_wr && (i_addr == OFF_EVT_STATUS);
   wire wr_mask  = i_wr && (i_addr == OFF_EVT_MASK);

   // Flag bits: one shared cell per flag
   wire [2:0] src_set = {i_src.lc2, i_src.lc1, i_src.lpw};
   wire [2:0] flag_wr = {wr_flag6, wr_flag6, wr_flag5};
   wire [2:0] flag_val = {i_wdata[BIT_LC2_FLAG], i_wdata[BIT_LC1_FLAG],
                          i_wdata[BIT_LPW_FLAG]};
   logic [2:0] flags;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_flag
         ifr_flag_bit u_flag (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .i_hw_set   (src_set[g]),   // see RULE3 see RULE15
            .i_sw_wr    (flag_wr[g]),
            .i_sw_val   (flag_val[g]),
            .o_flag     (flags[g])
         );
      end
   endgenerate

   // Flag images, unimplemented bits tied low
   wire [15:0] flag5_img = {15'h0000, flags[0]};      // see RULE1 see RULE10
   wire [15:0] flag6_img = {14'h0000, flags[2:1]};    // see RULE2 see RULE10

   // Request terms: flag and enable both set
   ifr_req_t req_d;
   assign req_d.lpw          = flags[0] & en_five_q[BIT_LPW_EN];  // see RULE14
   assign req_d.lc1          = flags[1] & en_six_q[BIT_LC1_EN];   // see RULE14
   assign req_d.lc2          = flags[2] & en_six_q[BIT_LC2_EN];   // see RULE14
   // Flags for these sources live elsewhere; enable gates raw request
   assign req_d.cc5_timer    = i_cc5_timer_req & en_two_q[BIT_CC5_EN];
   assign req_d.calendar     = i_calendar_req & en_three_q[BIT_CAL_EN];
   assign req_d.s2_collision = i_s2_collision_req
                               & en_three_q[BIT_S2COL_EN];        // see RULE9
   assign req_d.s2_event     = i_s2_event_req & en_three_q[BIT_S2EVT_EN];

   // Wake unit: idle stop only matters while the unit is on
   wire wake_active_d = wake_ctrl_q[BIT_WAKE_ON]
                        & ~(i_idle & wake_ctrl_q[BIT_WAKE_IDLE]); // see RULE12
   wire sink_d = wake_ctrl_q[BIT_WAKE_SINK];                     // see RULE13

   // Event status: rising flag sets of the three local flags
   wire [2:0]  src_rise = src_set & ~src_prev_q;
   wire [15:0] evt_set  = {13'h0000, src_rise};
   wire [15:0] evt_clr  = wr_stat ? (i_wdata & MSK_EVT) : RST_VALUE;
   wire [15:0] evt_d    = (evt_stat_q & ~evt_clr) | evt_set;
   wire        irq_d    = |(evt_d & evt_mask_q);

   // Read mux, unmapped reads zero
   logic [15:0] rd_mux;
   always_comb begin
      case (i_addr)
         OFF_FLAG_FIVE:  rd_mux = flag5_img;
         OFF_FLAG_SIX:   rd_mux = flag6_img;
         OFF_EN_TWO:     rd_mux = en_two_q;
         OFF_EN_THREE:   rd_mux = en_three_q;
         OFF_EN_FIVE:    rd_mux = en_five_q;
         OFF_EN_SIX:     rd_mux = en_six_q;
         OFF_WAKE_CTRL:  rd_mux = wake_ctrl_q;
         OFF_EVT_STATUS: rd_mux = evt_stat_q;
         OFF_EVT_MASK:   rd_mux = evt_mask_q;
         default:        rd_mux = RST_VALUE;
      endcase
   end

   // Writes masked so unimplemented bits stay zero
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         en_two_q    <= RST_VALUE;   // see RULE9
         en_three_q  <= RST_VALUE;
         en_five_q   <= RST_VALUE;
         en_six_q    <= RST_VALUE;
         wake_ctrl_q <= RST_VALUE;   // see RULE11
      end else begin
         if (wr_en2) en_two_q <= i_wdata & MSK_EN_TWO;         // see RULE4
         if (wr_en3) en_three_q <= i_wdata & MSK_EN_THREE; // see RULE5 RULE6
         if (wr_en5) en_five_q <= i_wdata & MSK_EN_FIVE;       // see RULE7
         if (wr_en6) en_six_q <= i_wdata & MSK_EN_SIX;         // see RULE8
         if (wr_wake) wake_ctrl_q <= i_wdata & MSK_WAKE_CTRL;  // see RULE11
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         evt_stat_q <= RST_VALUE;
         evt_mask_q <= RST_VALUE;
         src_prev_q <= 3'h0;
      end else begin
         evt_stat_q <= evt_d;
         if (wr_mask) evt_mask_q <= i_wdata & MSK_EVT;
         src_prev_q <= src_set;
      end
   end

   // Registered outputs
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q       <= RST_VALUE;
         req_q         <= '0;
         wake_active_q <= 1'b0;
         sink_q        <= 1'b0;
         irq_q         <= 1'b0;
      end else begin
         rdata_q       <= i_rd ? rd_mux : RST_VALUE;
         req_q         <= req_d;
         wake_active_q <= wake_active_d;
         sink_q        <= sink_d;
         irq_q         <= irq_d;
      end
   end

   assign o_rdata       = rdata_q;
   assign o_req         = req_q;
   assign o_wake_active = wake_active_q;
   assign o_wake_sink_on = sink_q;
   assign o_irq         = irq_q;

   // Checks
   a_lpw_req_gate: assert property ( // see RULE14
      o_req.lpw == $past(flags[0] & en_five_q[BIT_LPW_EN]))
      else $error("wake request not flag and enable");
   a_lc_req_gate: assert property ( // see RULE8
      o_req.lc2 |-> $past(flags[2]) && $past(en_six_q[BIT_LC2_EN]))
      else $error("cell2 request without flag and enable");
   a_flag_set_wins: assert property ( // see RULE15
      i_src.lpw |=> flags[0])
      else $error("hardware set lost");
   a_flag_sw_clear: assert property ( // see RULE3
      wr_flag6 && !i_wdata[0] && !i_src.lc1 |=> !flags[1])
      else $error("software clear ignored");
   a_unimpl_zero: assert property ( // see RULE10
      $past(i_rd && i_addr == OFF_EN_THREE) |-> (o_rdata & ~MSK_EN_THREE) == 0)
      else $error("unimplemented bit read nonzero");
   a_en_two_wr: assert property ( // see RULE4
      wr_en2 |=> en_two_q[BIT_CC5_EN] == $past(i_wdata[BIT_CC5_EN]))
      else $error("timer enable not written");
   a_cal_req: assert property ( // see RULE5
      i_calendar_req && !en_three_q[BIT_CAL_EN] |=> !o_req.calendar)
      else $error("calendar request not blocked");
   a_idle_stop: assert property ( // see RULE12
      wake_ctrl_q[BIT_WAKE_IDLE] && i_idle |=> !o_wake_active)
      else $error("wake unit ran in idle");
   a_sink_follow: assert property ( // see RULE13
      wr_wake ##1 1'b1 |=> o_wake_sink_on == $past(i_wdata[BIT_WAKE_SINK], 2))
      else $error("sink does not follow control");
   a_wake_on: assert property ( // see RULE11
      !wake_ctrl_q[BIT_WAKE_ON] |=> !o_wake_active)
      else $error("wake unit active while off");

   c_lpw_req: cover property (@(posedge i_core_clk) disable iff (i_rst)
      o_req.lpw);
   c_set_vs_clr: cover property (@(posedge i_core_clk) disable iff (i_rst)
      wr_flag6 && i_src.lc1 && !i_wdata[0]);
   c_irq: cover property (@(posedge i_core_clk) disable iff (i_rst) o_irq);
   c_idle_stop: cover property (@(posedge i_core_clk) disable iff (i_rst)
      wake_ctrl_q[BIT_WAKE_ON] && i_idle && wake_ctrl_q[BIT_WAKE_IDLE]);
endmodule : ifr_regs

/* dv/ifr_src_model.sv */
// Request-source model: one-cycle flag events and held raw requests
`timescale 1ns/10ps
module ifr_src_model
   import ifr_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire ifr_pkg::ifr_src_t i_fire,
   input  wire logic [3:0]        i_raw,
   output ifr_pkg::ifr_src_t      o_src,
   output logic [3:0]             o_raw
);
   // Registered so events leave on a clock edge, like a real peripheral
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_src <= '0;
         o_raw <= '0;
      end else begin
         o_src <= i_fire;
         o_raw <= i_raw;
      end
   end
endmodule : ifr_src_model

/* dv/ifr_regs_tb.sv */
// Self-checking bench for the flag and enable registers
`timescale 1ns/10ps
module ifr_regs_tb;
   import ifr_pkg::*;
   logic              i_core_clk = 1'b0;
   logic              i_rst = 1'b1;
   logic [3:0]        i_addr = 4'h0;
   logic [15:0]       i_wdata = 16'h0000;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic              i_idle = 1'b0;
   logic [3:0]        raw = 4'h0;
   ifr_src_t          fire = '0;
   ifr_src_t          src;
   logic [3:0]        raw_q;
   logic [15:0]       o_rdata;
   ifr_req_t          o_req;
   logic              o_wake_active;
   logic              o_wake_sink_on;
   logic              o_irq;
   logic [15:0]       rv;
   int                errors = 0;
   int                n_checks = 0;
   logic [3:0]        ta [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                 4'h4, 4'h5, 4'h6, 4'h9};
   logic [15:0]       te [8] = '{16'h0001, 16'h0003, 16'h0200, 16'h4006,
                                 16'h0001, 16'h0003, 16'hA100, 16'h0000};

   always #5 i_core_clk = ~i_core_clk;

   ifr_src_model u_ifr_src_model (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_fire(fire), .i_raw(raw), .o_src(src), .o_raw(raw_q));

   ifr_regs u_ifr_regs (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_src(src), .i_cc5_timer_req(raw_q[3]), .i_calendar_req(raw_q[2]),
      .i_s2_collision_req(raw_q[1]), .i_s2_event_req(raw_q[0]),
      .i_idle(i_idle), .o_rdata(o_rdata), .o_req(o_req),
      .o_wake_active(o_wake_active), .o_wake_sink_on(o_wake_sink_on),
      .o_irq(o_irq));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
   endtask : wr

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask : rd

   task automatic pulse(input logic [2:0] v);
      @(posedge i_core_clk);
      fire <= ifr_src_t'(v);
      @(posedge i_core_clk);
      fire <= '0;
      cyc(4);
   endtask : pulse

   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   initial begin
      #20000;
      errors++;
      end_sim();
   end

   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst <= 1'b0;
      for (int a = 0; a < 9; a++) rd(4'(a), 16'h0000);
      // Write all ones, read back only the implemented bits
      for (int i = 0; i < 8; i++) begin
         wr(ta[i], 16'hFFFF);
         rd(ta[i], te[i]);
      end
      cyc(2);
      chk({15'h0000, o_wake_active}, 16'h0001);
      chk({15'h0000, o_wake_sink_on}, 16'h0001);
      i_idle <= 1'b1;
      cyc(3);
      chk({15'h0000, o_wake_active}, 16'h0000);
      i_idle <= 1'b0;
      wr(4'h6, 16'h0000);
      cyc(3);
      chk({15'h0000, o_wake_active}, 16'h0000);
      chk({15'h0000, o_wake_sink_on}, 16'h0000);
      chk({9'h000, o_req}, 16'h0007);
      raw <= 4'hF;
      cyc(4);
      chk({9'h000, o_req}, 16'h007F);
      for (int a = 2; a < 6; a++) wr(4'(a), 16'h0000);
      cyc(3);
      chk({9'h000, o_req}, 16'h0000);
      raw <= 4'h0;
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0000);
      wr(4'h4, 16'h0001);
      // Clearing write lands in the same cycle as a hardware set
      @(posedge i_core_clk);
      fire <= ifr_src_t'(3'b001);
      @(posedge i_core_clk);
      fire   <= '0;
      i_addr <= 4'h0;
      i_wdata <= 16'h0000;
      i_wr   <= 1'b1;
      @(posedge i_core_clk);
      i_wr   <= 1'b0;
      rd(4'h0, 16'h0001);
      cyc(2);
      chk({9'h000, o_req}, 16'h0001);
      wr(4'h0, 16'h0000);
      cyc(3);
      chk({9'h000, o_req}, 16'h0000);
      // Interrupt: clear, unmask only source lc1, raise masked and unmasked
      wr(4'h7, 16'h0007);
      wr(4'h8, 16'h0002);
      pulse(3'b001);
      chk({15'h0000, o_irq}, 16'h0000);
      rd(4'h7, 16'h0001);
      pulse(3'b010);
      chk({15'h0000, o_irq}, 16'h0001);
      wr(4'h7, 16'h0002);
      cyc(3);
      chk({15'h0000, o_irq}, 16'h0000);
      rd(4'h1, 16'h0003);
      end_sim();
   end
endmodule : ifr_regs_tb
